// ---- verilog/lsc_regs.sv ----
// led sink control registers: source select and current setting for three sinks
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - sink 0 source: 000 off, 001 on, 010 charger, 011..111 pins 3..7
// - sink 1 source uses the same decode as sink 0
// - sink 2 same decode; code 111 taken as pin 7
// - sink 0 current is (step count plus one) times shared step size
// - sink 1 current is (step count plus one) times shared step size
// - sink 2 current is (step count plus one) times shared step size
// - largest step count is 11000, 25 steps; higher codes are clamped
// - step size 00 0.6mA, 01 1.0mA, 10 1.2mA, 11 reserved
module lsc_regs (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // neighbour register and internal status
  input wire logic [1:0] SHARED_CURRENT_STEP_SIZE,
  input wire logic CHG_STATUS,
  // multipurpose pins
  input wire logic MULTIPURPOSE_PIN_3,
  input wire logic MULTIPURPOSE_PIN_4,
  input wire logic MULTIPURPOSE_PIN_5,
  input wire logic MULTIPURPOSE_PIN_6,
  input wire logic MULTIPURPOSE_PIN_7,
  // sink controls
  output logic [2:0] SINK_ON,
  output logic [15:0] SINK0_CURRENT_UA,
  output logic [15:0] SINK1_CURRENT_UA,
  output logic [15:0] SINK2_CURRENT_UA
);
  import lsc_pkg::*;

  typedef struct packed {
    logic [NUM_SINKS-1:0][7:0] ctrl;
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] pin_f;
    logic [7:0] rdata;
    logic [NUM_SINKS-1:0] on;
    logic [NUM_SINKS-1:0][15:0] cur;
  } lsc_state_s;

  lsc_state_s st_q, st_d;
  logic [NUM_PINS-1:0] pins_in;

  assign pins_in = {MULTIPURPOSE_PIN_7, MULTIPURPOSE_PIN_6, MULTIPURPOSE_PIN_5,
                    MULTIPURPOSE_PIN_4, MULTIPURPOSE_PIN_3};

  // index of the register at an address, NUM_SINKS when unmapped
  function automatic logic [1:0] lsc_decode(input logic [7:0] addr);
    unique case (addr)
      ADDR_SINK0: lsc_decode = 2'h0;
      ADDR_SINK1: lsc_decode = 2'h1;
      ADDR_SINK2: lsc_decode = 2'h2;
      default: lsc_decode = 2'(NUM_SINKS);
    endcase
  endfunction

  function automatic logic lsc_source(input logic [2:0] sel, input logic chg,
                                      input logic [NUM_PINS-1:0] pins);
    unique case (sel)
      SRC_OFF: lsc_source = 1'b0;
      SRC_ON: lsc_source = 1'b1;
      SRC_CHG: lsc_source = chg;
      default: lsc_source = pins[3'(sel - SRC_PIN3)];
    endcase
  endfunction

  function automatic logic [15:0] lsc_step_ua(input logic [1:0] step);
    unique case (step)
      STEP_0P6: lsc_step_ua = STEP_UA_0P6;
      STEP_1P0: lsc_step_ua = STEP_UA_1P0;
      STEP_1P2: lsc_step_ua = STEP_UA_1P2;
      default: lsc_step_ua = STEP_UA_RSVD;
    endcase
  endfunction

  function automatic logic [15:0] lsc_current(input logic [4:0] cnt, input logic [1:0] step);
    logic [4:0] c;
    c = (cnt > CNT_MAX) ? CNT_MAX : cnt;
    lsc_current = 16'((16'(c) + 16'h0001) * lsc_step_ua(step));
  endfunction

  always_comb begin
    logic [1:0] idx;
    idx = lsc_decode(REG_ADDR);
    st_d = st_q;
    // pins come from off-chip: three stages, accept once stages two and three agree
    st_d.sync1 = pins_in;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (st_q.sync2[i] == st_q.sync3[i]) begin
        st_d.pin_f[i] = st_q.sync2[i];
      end
    end
    if (REG_WR && idx < 2'(NUM_SINKS)) begin
      st_d.ctrl[idx] = REG_WDATA;
    end
    if (REG_RD) begin
      st_d.rdata = (idx < 2'(NUM_SINKS)) ? st_q.ctrl[idx] : RDATA_UNMAPPED;
    end
    for (int s = 0; s < NUM_SINKS; s++) begin
      st_d.on[s] = lsc_source(st_q.ctrl[s][SRC_HI:SRC_LO], CHG_STATUS, st_q.pin_f);
      st_d.cur[s] = lsc_current(st_q.ctrl[s][CNT_HI:CNT_LO], SHARED_CURRENT_STEP_SIZE);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_q <= '0;
      st_q.ctrl <= {NUM_SINKS{CTRL_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  assign REG_RDATA = st_q.rdata;
  assign SINK_ON = st_q.on;
  assign SINK0_CURRENT_UA = st_q.cur[0];
  assign SINK1_CURRENT_UA = st_q.cur[1];
  assign SINK2_CURRENT_UA = st_q.cur[2];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence pin3_held_s;
    ($stable(MULTIPURPOSE_PIN_3) && st_q.ctrl[0][SRC_HI:SRC_LO] == SRC_PIN3)[*6];
  endsequence

  chk_sink0_off: assert property (
    st_q.ctrl[0][SRC_HI:SRC_LO] == SRC_OFF |=> !SINK_ON[0])
    else $error("sink 0 on while source is off");
  chk_sink1_charger: assert property (
    st_q.ctrl[1][SRC_HI:SRC_LO] == SRC_CHG |=> SINK_ON[1] == $past(CHG_STATUS))
    else $error("sink 1 does not follow charger status");
  chk_sink2_pin7: assert property (
    st_q.ctrl[2][SRC_HI:SRC_LO] == SRC_PIN7 |=> SINK_ON[2] == $past(st_q.pin_f[4]))
    else $error("sink 2 does not follow pin 7");
  // outputs lag reset release by one edge, so the release edge itself is left out
  chk_sink0_current: assert property (
    RST_B && st_q.ctrl[0][CNT_HI:CNT_LO] == 5'h00 && SHARED_CURRENT_STEP_SIZE == STEP_1P0
    |=> SINK0_CURRENT_UA == STEP_UA_1P0)
    else $error("sink 0 current wrong for one step");
  chk_sink1_current: assert property (
    st_q.ctrl[1][CNT_HI:CNT_LO] == 5'h09 && SHARED_CURRENT_STEP_SIZE == STEP_0P6
    |=> SINK1_CURRENT_UA == 16'h1770)
    else $error("sink 1 current wrong for ten steps");
  chk_sink2_current: assert property (
    RST_B && SHARED_CURRENT_STEP_SIZE == STEP_1P2 && st_q.ctrl[2][CNT_HI:CNT_LO] <= CNT_MAX
    |=> SINK2_CURRENT_UA ==
        16'((16'($past(st_q.ctrl[2][CNT_HI:CNT_LO])) + 16'h0001) * STEP_UA_1P2))
    else $error("sink 2 current formula broken");
  chk_count_clamp: assert property (
    st_q.ctrl[0][CNT_HI:CNT_LO] > CNT_MAX && SHARED_CURRENT_STEP_SIZE == STEP_0P6
    |=> SINK0_CURRENT_UA == 16'h3a98)
    else $error("step count above 11000 not clamped");
  chk_step_reserved: assert property (
    SHARED_CURRENT_STEP_SIZE == 2'h3 |=> SINK0_CURRENT_UA == STEP_UA_RSVD
    && SINK1_CURRENT_UA == STEP_UA_RSVD && SINK2_CURRENT_UA == STEP_UA_RSVD)
    else $error("reserved step size drives current");
  chk_pin_follow: assert property (
    pin3_held_s |-> SINK_ON[0] == MULTIPURPOSE_PIN_3)
    else $error("sink 0 does not follow a steady pin 3");

  // write, register, output: the always-on code shows two edges after the write edge
  sequence sink0_on_write_s;
    REG_WR && REG_ADDR == ADDR_SINK0 && REG_WDATA[SRC_HI:SRC_LO] == SRC_ON;
  endsequence

  sequence ctrl0_on_s;
    st_q.ctrl[0][SRC_HI:SRC_LO] == SRC_ON;
  endsequence

  chk_write_sink0_on: assert property (
    sink0_on_write_s |=> ctrl0_on_s ##1 SINK_ON[0])
    else $error("sink 0 not on two edges after an always-on write");

  // code 110 is the last plain pin code on sink 2, below the 111 choice
  chk_sink2_pin6: assert property (
    st_q.ctrl[2][SRC_HI:SRC_LO] == 3'(SRC_PIN7 - 3'h1)
    |=> SINK_ON[2] == $past(st_q.pin_f[3]))
    else $error("sink 2 does not follow pin 6");
  chk_sink1_step_1p2: assert property (
    RST_B && st_q.ctrl[1][CNT_HI:CNT_LO] == 5'h00 && SHARED_CURRENT_STEP_SIZE == STEP_1P2
    |=> SINK1_CURRENT_UA == STEP_UA_1P2)
    else $error("sink 1 current wrong for the largest step size");
  chk_sink2_clamp: assert property (
    st_q.ctrl[2][CNT_HI:CNT_LO] > CNT_MAX && SHARED_CURRENT_STEP_SIZE == STEP_1P0
    |=> SINK2_CURRENT_UA == 16'h61a8)
    else $error("sink 2 step count above 11000 not clamped");

  // filter passes a pin only when stages two and three agree, so one-edge glitches never reach a sink
  sequence pins_settled_s;
    st_q.sync2 == st_q.sync3;
  endsequence

  chk_filter_pass: assert property (
    pins_settled_s |=> st_q.pin_f == $past(st_q.sync2))
    else $error("pin filter did not take a settled pin");
  chk_filter_hold: assert property (
    st_q.sync2[0] != st_q.sync3[0] |=> $stable(st_q.pin_f[0]))
    else $error("pin filter moved while stages disagree");

  // a read answers on the next edge with the byte as stored
  sequence sink1_read_s;
    REG_RD && REG_ADDR == ADDR_SINK1;
  endsequence

  chk_sink1_readback: assert property (
    sink1_read_s |=> REG_RDATA == $past(st_q.ctrl[1]))
    else $error("sink 1 control byte not read back");
endmodule // lsc_regs

`default_nettype wire

// ---- verilog/lsc_pkg.sv ----
// constants for the led sink control register bank
package lsc_pkg;
  localparam int unsigned NUM_SINKS = 3;
  localparam int unsigned NUM_PINS = 5;
  localparam logic [7:0] ADDR_SINK0 = 8'h7a;
  localparam logic [7:0] ADDR_SINK1 = 8'h7b;
  localparam logic [7:0] ADDR_SINK2 = 8'h7c;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam int unsigned SRC_HI = 7;
  localparam int unsigned SRC_LO = 5;
  localparam int unsigned CNT_HI = 4;
  localparam int unsigned CNT_LO = 0;
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_ON = 3'h1;
  localparam logic [2:0] SRC_CHG = 3'h2;
  localparam logic [2:0] SRC_PIN3 = 3'h3;
  localparam logic [2:0] SRC_PIN7 = 3'h7;
  localparam logic [4:0] CNT_MAX = 5'h18;
  localparam logic [1:0] STEP_0P6 = 2'h0;
  localparam logic [1:0] STEP_1P0 = 2'h1;
  localparam logic [1:0] STEP_1P2 = 2'h2;
  localparam logic [15:0] STEP_UA_0P6 = 16'h0258;
  localparam logic [15:0] STEP_UA_1P0 = 16'h03e8;
  localparam logic [15:0] STEP_UA_1P2 = 16'h04b0;
  localparam logic [15:0] STEP_UA_RSVD = 16'h0000;
endpackage

// ---- verif/lsc_regs_tb.sv ----
// self-checking bench for the led sink control registers
`timescale 1ns/1ps
`default_nettype none
module lsc_regs_tb;
  import lsc_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic REG_WR = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic [1:0] SHARED_CURRENT_STEP_SIZE = 2'h0;
  logic CHG_STATUS = 1'b0;
  logic [4:0] pins = 5'h00;
  logic [2:0] SINK_ON;
  logic [15:0] SINK0_CURRENT_UA, SINK1_CURRENT_UA, SINK2_CURRENT_UA;
  logic snap = 1'b0, rd_p = 1'b0;
  logic [7:0] regs [3];
  logic [7:0] rq [$];
  logic [50:0] sq [$];
  logic [50:0] sexp;
  logic [31:0] seed = 32'h40;
  int failures = 0;
  int checks_done = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  lsc_regs uut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .SHARED_CURRENT_STEP_SIZE(SHARED_CURRENT_STEP_SIZE), .CHG_STATUS(CHG_STATUS),
    .MULTIPURPOSE_PIN_3(pins[0]), .MULTIPURPOSE_PIN_4(pins[1]), .MULTIPURPOSE_PIN_5(pins[2]),
    .MULTIPURPOSE_PIN_6(pins[3]), .MULTIPURPOSE_PIN_7(pins[4]), .SINK_ON(SINK_ON),
    .SINK0_CURRENT_UA(SINK0_CURRENT_UA), .SINK1_CURRENT_UA(SINK1_CURRENT_UA),
    .SINK2_CURRENT_UA(SINK2_CURRENT_UA));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic close_out();
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic err(input string m);
    failures++;
    $display("ERROR %0t %s", $time, m);
  endtask
  // one access per edge; the next call overwrites the strobes, so none is set twice
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_WR <= w;
    REG_RD <= r;
    REG_ADDR <= a;
    REG_WDATA <= d;
    if (w && a >= ADDR_SINK0 && a <= ADDR_SINK2) regs[int'(a - ADDR_SINK0)] = d;
    if (r) rq.push_back((a >= ADDR_SINK0 && a <= ADDR_SINK2) ?
      regs[int'(a - ADDR_SINK0)] : RDATA_UNMAPPED);
  endtask
  // unmapped write first, then back-to-back reads around the bank
  task automatic rd_all();
    cyc(1'b1, 1'b0, 8'h79, 8'hff);
    for (int i = 0; i < 5; i++) cyc(1'b0, 1'b1, 8'(8'h79 + i), 8'h00);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic expect_sinks();
    logic [2:0] on;
    logic [47:0] cur;
    logic [15:0] ua;
    logic [2:0] src;
    logic [4:0] cnt;
    case (SHARED_CURRENT_STEP_SIZE)
      STEP_0P6: ua = STEP_UA_0P6;
      STEP_1P0: ua = STEP_UA_1P0;
      STEP_1P2: ua = STEP_UA_1P2;
      default: ua = STEP_UA_RSVD;
    endcase
    for (int n = 0; n < 3; n++) begin
      src = regs[n][7:5];
      cnt = regs[n][4:0];
      on[n] = src == SRC_OFF ? 1'b0 : src == SRC_ON ? 1'b1 : src == SRC_CHG ? CHG_STATUS :
        pins[src - SRC_PIN3];
      cur[16*n +: 16] = 16'((cnt > CNT_MAX ? CNT_MAX : cnt) + 5'h01) * ua;
    end
    sq.push_back({on, cur});
    @(posedge CLK_SYS);
    snap <= 1'b1;
    @(posedge CLK_SYS);
    snap <= 1'b0;
  endtask
  // read data stands from the edge that takes the read, so look half a cycle after it
  always @(posedge CLK_SYS) begin
    rd_p <= REG_RD;
  end
  always @(negedge CLK_SYS) begin
    if (rd_p) begin
      checks_done++;
      if (rq.size() == 0 || REG_RDATA !== rq.pop_front()) err("read data mismatch");
    end
    if (snap) begin
      checks_done += 4;
      sexp = sq.pop_front();
      if (SINK_ON !== sexp[50:48]) err("sink enable mismatch");
      if (SINK0_CURRENT_UA !== sexp[15:0]) err("sink 0 current");
      if (SINK1_CURRENT_UA !== sexp[31:16]) err("sink 1 current");
      if (SINK2_CURRENT_UA !== sexp[47:32]) err("sink 2 current");
    end
  end
  initial begin
    repeat (3) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    for (int n = 0; n < 3; n++) regs[n] = CTRL_RST;
    rd_all();
    for (int it = 0; it < 300; it++) begin
      @(posedge CLK_SYS);
      seed = rnd();
      SHARED_CURRENT_STEP_SIZE <= seed[1:0];
      CHG_STATUS <= seed[2];
      pins <= seed[7:3];
      for (int n = 0; n < 3; n++) cyc(1'b1, 1'b0, 8'(ADDR_SINK0 + n), 8'(rnd()));
      cyc(1'b0, 1'b0, 8'h00, 8'h00);
      // pins need five edges through the synchroniser and filter
      repeat (6) @(posedge CLK_SYS);
      expect_sinks();
      rd_all();
    end
    RST_B <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    for (int n = 0; n < 3; n++) regs[n] = CTRL_RST;
    rd_all();
    expect_sinks();
    repeat (3) @(posedge CLK_SYS);
    close_out();
  end
  initial begin
    repeat (50000) @(posedge CLK_SYS);
    failures++;
    close_out();
  end
endmodule // lsc_regs_tb
`default_nettype wire
